// File: load_filter.v
`include "motor_load_measure_regs.vh"
`default_nettype none

module load_filter
#(
  parameter WIDTH = 10,
  parameter SHIFT = `FILTER_SHIFT
)
(
  // clock and reset
  input  wire             i_clk,
  input  wire             i_reset,
  // mode
  input  wire             i_filter_enable,
  // one sample per full step
  input  wire             i_sample_valid,
  input  wire [WIDTH-1:0] i_sample,
  // result
  output wire             o_result_valid,
  output wire [WIDTH-1:0] o_result
);

  localparam SUM_W = WIDTH + SHIFT;
  localparam [SHIFT-1:0] LAST = {SHIFT{1'b1}};

  reg [SUM_W-1:0] sum_reg;
  reg [SHIFT-1:0] count_reg;
  reg [WIDTH-1:0] result_reg;
  reg             valid_reg;
  wire [SUM_W-1:0] sum_now;

  assign sum_now = sum_reg + {{SHIFT{1'b0}}, i_sample};
  assign o_result_valid = valid_reg;
  assign o_result = result_reg;

  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      sum_reg    <= {SUM_W{1'b0}};
      count_reg  <= {SHIFT{1'b0}};
      result_reg <= {WIDTH{1'b0}};
      valid_reg  <= 1'b0;
    end
    else
    begin
      valid_reg <= 1'b0;
      if (!i_filter_enable)
      begin
        // a mode change restarts the group so no result mixes modes
        sum_reg   <= {SUM_W{1'b0}};
        count_reg <= {SHIFT{1'b0}};
        if (i_sample_valid)
        begin
          result_reg <= i_sample;
          valid_reg  <= 1'b1;
        end
      end
      else if (i_sample_valid)
      begin
        if (count_reg == LAST)
        begin
          // mean of the four latest steps, truncated
          result_reg <= sum_now[SUM_W-1:SHIFT];
          valid_reg  <= 1'b1;
          sum_reg    <= {SUM_W{1'b0}};
          count_reg  <= {SHIFT{1'b0}};
        end
        else
        begin
          sum_reg   <= sum_now;
          count_reg <= count_reg + {{(SHIFT-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

`default_nettype wire

// File: mlm_chk_asserts.sv
`default_nettype none
module mlm_chk (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // bus
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic o_wb_ack,
  // pins
  input wire logic i_full_step,
  input wire logic i_ext_clk_level,
  input wire logic o_ext_clk_select,
  input wire logic o_stall_flag_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       step_d_reg;
  logic [3:0] since_reg;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // saturating age of the last step edge, so stall moves can be tied to it
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      step_d_reg <= 1'b0;
      since_reg  <= 4'hF;
    end
    else
    begin
      step_d_reg <= i_full_step;
      if (i_full_step && !step_d_reg)
        since_reg <= 4'h0;
      else if (since_reg != 4'hF)
        since_reg <= since_reg + 4'h1;
    end
  end
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
    |=> o_wb_ack) else $error("ack missing");
  a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  a_stall_step: assert property ($changed(o_stall_flag_out)
    |-> since_reg inside {[4'h2:4'h8]}) else $error("stall off step");
  a_ext_sticky: assert property (o_ext_clk_select
    |=> o_ext_clk_select) else $error("clock select dropped");
  a_ext_cause: assert property ($rose(o_ext_clk_select)
    |-> $past(i_ext_clk_level, 2)) else $error("select without pin");
  a_ext_prompt: assert property ($rose(i_ext_clk_level)
    |-> ##[1:8] o_ext_clk_select) else $error("select late");
  a_reset_quiet: assert property ($fell(i_reset)
    |-> !o_wb_ack && !o_stall_flag_out && !o_ext_clk_select)
    else $error("outputs busy after reset");
  c_stall: cover property ($rose(o_stall_flag_out));
  c_ext: cover property ($rose(o_ext_clk_select));
  c_ack: cover property (o_wb_ack && i_wb_cyc);
endmodule
`default_nettype wire

// File: motor_load_measure.v
// Function
// - the threshold is a seven-bit signed value for stall level and range.
// - zero is neutral; positive needs more load to stall, negative is keener.
// - filter bit set gives one result per four full steps, else unfiltered.
// - unfiltered, the load value is refreshed once per full step.
// - the load value is ten-bit unsigned, high for light load, zero highest.
// - the stall output is asserted when the load value falls to zero.
// - the stall output is active high.
// - system clock is the internal oscillator or an external clock.
// - internal oscillator while clock pin low; high stops it to power-down. Here the select stays set until reset, even after the pin goes low.
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`include "motor_load_measure_regs.vh"
`default_nettype none

module motor_load_measure
(
  // clock and reset
  input  wire        i_clk,
  input  wire        i_reset,
  // wishbone classic slave
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  input  wire        i_wb_we,
  input  wire [7:0]  i_wb_adr,
  input  wire [3:0]  i_wb_sel,
  input  wire [31:0] i_wb_dat,
  output wire [31:0] o_wb_dat,
  output wire        o_wb_ack,
  // measurement front end
  input  wire        i_full_step,
  input  wire [9:0]  i_raw_load,
  // clock selector pin
  input  wire        i_ext_clk_level,
  output wire        o_ext_clk_select,
  // stall pin and interrupt
  output wire        o_stall_flag_out,
  output wire        o_irq
);

  // address match, used by read mux and write strobes alike
  function hit;
    input [7:0] adr;
    input [7:0] ofs;
    begin
      hit = (adr[7:2] == ofs[7:2]);
    end
  endfunction

  // threshold offset added to the raw figure, result clamped to range
  function [9:0] apply_threshold;
    input [9:0] raw;
    input [6:0] thresh;
    reg   [11:0] scaled;
    reg   [11:0] sum;
    begin
      scaled = {{5{thresh[6]}}, thresh} << `THRESH_SHIFT;
      sum = {2'b00, raw} + scaled;
      if (sum[11])
        apply_threshold = 10'h000;
      else if (sum[10])
        apply_threshold = `LOAD_VALUE_MAX;
      else
        apply_threshold = sum[9:0];
    end
  endfunction

  // bus state
  reg        ack_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rdata_next;
  wire       bus_req;
  wire       wr_commit;

  // configuration
  reg [6:0]  load_sens_threshold_reg;
  reg        load_filter_enable_reg;

  // measurement state
  reg [9:0]  load_value_reg;
  reg        stall_reg;
  reg [9:0]  load_min_reg;
  reg [15:0] step_count_reg;
  reg        measured_reg;

  // synchronisers, three stages each
  reg [2:0]  step_sync_reg;
  reg        step_stable_reg;
  reg [2:0]  clk_sync_reg;
  reg        ext_clk_reg;

  // interrupts
  reg [`IRQ_WIDTH-1:0] irq_status_reg;
  reg [`IRQ_WIDTH-1:0] irq_enable_reg;
  reg [`IRQ_WIDTH-1:0] irq_event;
  wire [`IRQ_WIDTH-1:0] irq_clear;

  wire       step_event;
  wire [9:0] sample;
  wire       result_valid;
  wire [9:0] result;

  assign bus_req   = i_wb_cyc & i_wb_stb;
  // a write takes effect only at the edge where the master sees ack
  assign wr_commit = bus_req & i_wb_we & ack_reg;
  assign o_wb_ack  = ack_reg;
  assign o_wb_dat  = rdata_reg;

  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      ack_reg <= bus_req & ~ack_reg;
      if (bus_req & ~ack_reg)
        rdata_reg <= rdata_next;
    end
  end

  // unmapped and write-only offsets read as zero and are still acked
  always @*
  begin
    rdata_next = 32'h00000000;
    if (hit(i_wb_adr, `REG_CONFIG_OFS))
    begin
      rdata_next[`CFG_THRESH_MSB:`CFG_THRESH_LSB] = load_sens_threshold_reg;
      rdata_next[`CFG_FILTER_BIT] = load_filter_enable_reg;
    end
    else if (hit(i_wb_adr, `REG_LOAD_OFS))
    begin
      rdata_next[`LOAD_VALUE_MSB:`LOAD_VALUE_LSB] = load_value_reg;
      rdata_next[`LOAD_STALL_BIT] = stall_reg;
      rdata_next[`LOAD_EXT_CLK_BIT] = ext_clk_reg;
    end
    else if (hit(i_wb_adr, `REG_IRQ_STATUS_OFS))
      rdata_next[`IRQ_WIDTH-1:0] = irq_status_reg;
    else if (hit(i_wb_adr, `REG_IRQ_ENABLE_OFS))
      rdata_next[`IRQ_WIDTH-1:0] = irq_enable_reg;
    else if (hit(i_wb_adr, `REG_LOAD_MIN_OFS))
      rdata_next[9:0] = load_min_reg;
    else if (hit(i_wb_adr, `REG_STEP_COUNT_OFS))
      rdata_next[15:0] = step_count_reg;
  end

  // configuration writes, byte lanes honoured
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      load_sens_threshold_reg <= `CFG_THRESH_RESET;
      load_filter_enable_reg  <= `CFG_FILTER_RESET;
      irq_enable_reg          <= {`IRQ_WIDTH{1'b0}};
    end
    else if (wr_commit)
    begin
      if (hit(i_wb_adr, `REG_CONFIG_OFS))
      begin
        if (i_wb_sel[0])
          load_sens_threshold_reg <=
            i_wb_dat[`CFG_THRESH_MSB:`CFG_THRESH_LSB];
        if (i_wb_sel[1])
          load_filter_enable_reg <= i_wb_dat[`CFG_FILTER_BIT];
      end
      else if (hit(i_wb_adr, `REG_IRQ_ENABLE_OFS))
      begin
        if (i_wb_sel[0])
          irq_enable_reg <= i_wb_dat[`IRQ_WIDTH-1:0];
      end
    end
  end

  // full-step pin: a level counts once stages two and three agree
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      step_sync_reg   <= 3'h0;
      step_stable_reg <= 1'b0;
    end
    else
    begin
      step_sync_reg <= {step_sync_reg[1:0], i_full_step};
      if (step_sync_reg[1] == step_sync_reg[2])
        step_stable_reg <= step_sync_reg[2];
    end
  end

  assign step_event = (step_sync_reg[1] == step_sync_reg[2]) &
                      step_sync_reg[2] & ~step_stable_reg;

  // external clock pin: once seen high the oscillator stays off until
  // reset, which stands for power-down here; the actual clock switch is
  // outside this logic, this is only the selector state
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      clk_sync_reg <= 3'h0;
      ext_clk_reg  <= 1'b0;
    end
    else
    begin
      clk_sync_reg <= {clk_sync_reg[1:0], i_ext_clk_level};
      if (clk_sync_reg[1] & clk_sync_reg[2])
        ext_clk_reg <= 1'b1;
    end
  end

  assign o_ext_clk_select = ext_clk_reg;

  // raw figure offset by the threshold, sampled on the step edge
  assign sample = apply_threshold(i_raw_load,
                                  load_sens_threshold_reg);

  load_filter
  #(
    .WIDTH (10),
    .SHIFT (`FILTER_SHIFT)
  )
  u_filter
  (
    .i_clk           (i_clk),
    .i_reset         (i_reset),
    .i_filter_enable (load_filter_enable_reg),
    .i_sample_valid  (step_event),
    .i_sample        (sample),
    .o_result_valid  (result_valid),
    .o_result        (result)
  );

  // reported value, stall pin and tuning aids
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      load_value_reg <= `LOAD_VALUE_RESET;
      stall_reg      <= 1'b0;
      measured_reg   <= 1'b0;
      load_min_reg   <= `LOAD_VALUE_MAX;
      step_count_reg <= 16'h0000;
    end
    else
    begin
      if (step_event)
        step_count_reg <= step_count_reg + 16'h0001;
      if (result_valid)
      begin
        load_value_reg <= result;
        measured_reg   <= 1'b1;
        // stall pin follows the newest result, high at zero
        stall_reg      <= (result == 10'h000);
      end
      // minimum tracking helps tuning; a new lower result beats a restart
      if (result_valid && (result < load_min_reg))
        load_min_reg <= result;
      else if (wr_commit && hit(i_wb_adr, `REG_LOAD_MIN_OFS))
        load_min_reg <= `LOAD_VALUE_MAX;
    end
  end

  assign o_stall_flag_out = stall_reg;

  // events: new result, stall onset, switch to external clock
  always @*
  begin
    irq_event = {`IRQ_WIDTH{1'b0}};
    irq_event[`IRQ_UPDATE_BIT] = result_valid;
    irq_event[`IRQ_STALL_BIT] = result_valid & (result == 10'h000) &
                                ~(stall_reg & measured_reg);
    irq_event[`IRQ_EXT_CLK_BIT] = clk_sync_reg[1] & clk_sync_reg[2] &
                                  ~ext_clk_reg;
  end

  assign irq_clear = (wr_commit && i_wb_sel[0] &&
                      hit(i_wb_adr, `REG_IRQ_CLEAR_OFS)) ?
                     i_wb_dat[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};

  genvar g;
  generate
    for (g = 0; g < `IRQ_WIDTH; g = g + 1)
    begin : irq_bits
      // an event in the clearing cycle is kept: set wins
      always @(posedge i_clk)
      begin
        if (i_reset)
          irq_status_reg[g] <= 1'b0;
        else if (irq_event[g])
          irq_status_reg[g] <= 1'b1;
        else if (irq_clear[g])
          irq_status_reg[g] <= 1'b0;
      end
    end
  endgenerate

  assign o_irq = |(irq_status_reg & irq_enable_reg);

endmodule

`default_nettype wire

// File: motor_load_measure_regs.vh
`ifndef MOTOR_LOAD_MEASURE_REGS_VH
`define MOTOR_LOAD_MEASURE_REGS_VH

// register byte offsets on the wishbone port
`define REG_CONFIG_OFS        8'h00
`define REG_LOAD_OFS          8'h04
`define REG_IRQ_STATUS_OFS    8'h08
`define REG_IRQ_CLEAR_OFS     8'h0C
`define REG_IRQ_ENABLE_OFS    8'h10
`define REG_LOAD_MIN_OFS      8'h14
`define REG_STEP_COUNT_OFS    8'h18

// configuration register fields
`define CFG_THRESH_LSB        0
`define CFG_THRESH_MSB        6
`define CFG_FILTER_BIT        8
`define CFG_THRESH_RESET      7'h00
`define CFG_FILTER_RESET      1'h0

// load register fields
`define LOAD_VALUE_LSB        0
`define LOAD_VALUE_MSB        9
`define LOAD_STALL_BIT        16
`define LOAD_EXT_CLK_BIT      17

// interrupt bits, shared by status, clear and enable
`define IRQ_UPDATE_BIT        0
`define IRQ_STALL_BIT         1
`define IRQ_EXT_CLK_BIT       2
`define IRQ_WIDTH             3

// load value range and threshold scaling
`define LOAD_VALUE_MAX        10'h3FF
`define LOAD_VALUE_RESET      10'h3FF
`define THRESH_SHIFT          4

// filter: four full steps per filtered result
`define FILTER_SHIFT          2

`endif

// File: motor_model.sv
`default_nettype none
module motor_model (
  // clock
  input  wire logic       i_clk,
  // step pin and raw load toward the unit
  output var  logic       o_full_step,
  output var  logic [9:0] o_raw_load
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    o_full_step = 1'b0;
    o_raw_load  = 10'h000;
  end
  // raw load is held to the next step since the unit samples it late
  task automatic step_once(input logic [9:0] load, input int gap);
    @(posedge i_clk);
    o_full_step <= 1'b1;
    o_raw_load  <= load;
    repeat (4) @(posedge i_clk);
    o_full_step <= 1'b0;
    repeat (gap) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// File: tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;
  logic        rst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        ack;
  logic        step;
  logic [9:0]  raw;
  logic        ext;
  logic        ext_sel;
  logic        stall;
  logic        irq;
  int          n_fail;
  int          samples_checked;
  int          cycles = 0;
  logic [6:0]  thr_t [6] = '{7'h00, 7'h00, 7'h01, 7'h3F, 7'h76, 7'h7F};
  logic [9:0]  raw_t [6] = '{10'h1F4, 10'h000, 10'h000, 10'h3E8, 10'h064,
                             10'h014};
  logic [9:0]  exp_t [6] = '{10'h1F4, 10'h000, 10'h010, 10'h3FF, 10'h000,
                             10'h004};
  motor_load_measure u_dut (
    .i_clk(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_full_step(step), .i_raw_load(raw),
    .i_ext_clk_level(ext), .o_ext_clk_select(ext_sel),
    .o_stall_flag_out(stall), .o_irq(irq));
  motor_model u_mot (.i_clk(clk), .o_full_step(step), .o_raw_load(raw));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_fail++;
      finish_test();
    end
  end
  initial
  begin
    n_fail = 0;
    samples_checked = 0;
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    ext = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, 8'h00, 32'h0, q);
    chk("config", 32'h0, q);
    wb(1'b0, 8'h04, 32'h0, q);
    chk("load", 32'h3FF, q);
    wb(1'b0, 8'hFC, 32'h0, q);
    chk("unmapped", 32'h0, q);
    wb(1'b1, 8'h10, 32'h3, q);
    // thresholds kept at minus ten or above
    for (int i = 0; i < 6; i++)
    begin
      wb(1'b1, 8'h00, {25'h0, thr_t[i]}, q);
      u_mot.step_once(raw_t[i], (i == 0) ? 20 : 4);
      wb(1'b0, 8'h04, 32'h0, q);
      chk("load", {15'h0, exp_t[i] == 10'h0, 6'h0, exp_t[i]}, q);
      chk("stall", {31'h0, exp_t[i] == 10'h0}, {31'h0, stall});
    end
    chk("irq", 32'h1, {31'h0, irq});
    wb(1'b0, 8'h08, 32'h0, q);
    chk("status", 32'h3, q);
    wb(1'b1, 8'h10, 32'h0, q);
    // the enable write lands at the ack edge; look one edge later
    @(posedge clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wb(1'b1, 8'h0C, 32'h7, q);
    wb(1'b0, 8'h08, 32'h0, q);
    chk("cleared", 32'h0, q);
    wb(1'b0, 8'h18, 32'h0, q);
    chk("steps", 32'h6, q);
    wb(1'b0, 8'h14, 32'h0, q);
    chk("min", 32'h0, q);
    wb(1'b1, 8'h00, 32'h100, q);
    u_mot.step_once(10'h064, 4);
    u_mot.step_once(10'h0C8, 4);
    u_mot.step_once(10'h12C, 4);
    wb(1'b0, 8'h04, 32'h0, q);
    chk("held", 32'h4, q);
    u_mot.step_once(10'h191, 4);
    wb(1'b0, 8'h04, 32'h0, q);
    chk("mean", 32'hFA, q);
    ext <= 1'b1;
    repeat (10) @(posedge clk);
    wb(1'b0, 8'h04, 32'h0, q);
    chk("ext", 32'h200FA, q);
    ext <= 1'b0;
    repeat (10) @(posedge clk);
    chk("ext held", 32'h1, {31'h0, ext_sel});
    // tuning: heavy load leaves 10 above zero, so the threshold goes down
    wb(1'b1, 8'h00, 32'h0, q);
    u_mot.step_once(10'h00A, 4);
    wb(1'b0, 8'h04, 32'h0, q);
    chk("tune load", 32'h2000A, q);
    wb(1'b1, 8'h00, 32'h7F, q);
    u_mot.step_once(10'h00A, 4);
    wb(1'b0, 8'h04, 32'h0, q);
    chk("tune stall", 32'h30000, q);
    u_mot.step_once(10'h1F4, 4);
    wb(1'b0, 8'h04, 32'h0, q);
    chk("tune free", 32'h201E4, q);
    chk("tune rise", 32'h1, {31'h0, q[9:0] >= 10'h064});
    finish_test();
  end
endmodule
bind motor_load_measure mlm_chk u_chk (
  .i_clk(i_clk), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .i_full_step(i_full_step),
  .i_ext_clk_level(i_ext_clk_level), .o_ext_clk_select(o_ext_clk_select),
  .o_stall_flag_out(o_stall_flag_out));
`default_nettype wire
